// [hdl/sgt_pkg.sv]
package sgt_pkg;

  // Register addresses
  localparam logic [7:0] SGT_ADDR_GAIN = 8'h86;
  localparam logic [7:0] SGT_ADDR_CFG = 8'h87;
  localparam logic [7:0] SGT_ADDR_UPPER = 8'h88;
  localparam logic [7:0] SGT_ADDR_LOWER = 8'h89;

  // Reset values
  localparam logic [15:0] SGT_GAIN_RESET = 16'h0000;
  localparam logic [7:0] SGT_CFG_RESET = 8'h00;
  localparam logic [15:0] SGT_UPPER_RESET = 16'h7fff;
  localparam logic [15:0] SGT_LOWER_RESET = 16'h8000;
  localparam logic [15:0] SGT_RDATA_NONE = 16'h0000;

  // Configuration field layout
  localparam int SGT_CFG_MSB = 15;
  localparam int SGT_CFG_LSB = 8;
  localparam logic [7:0] SGT_CFG_LOW_READ = 8'h00;

  // Threshold full-scale codes
  localparam logic [15:0] SGT_POS_FS = 16'h7fff;
  localparam logic [15:0] SGT_NEG_FS = 16'h8000;

  // Fast filter geometry
  localparam int SGT_OSR = 64;
  localparam int SGT_DEC_W = 6;
  localparam int SGT_INT_W = 19;
  localparam int SGT_CTR_W = 20;
  localparam logic [SGT_DEC_W-1:0] SGT_DEC_LAST = SGT_DEC_W'(SGT_OSR - 1);
  localparam logic signed [SGT_CTR_W-1:0] SGT_MID = 20'sh20000;
  localparam logic signed [SGT_CTR_W-1:0] SGT_SCALED_MAX = 20'sh07fff;
  localparam int SGT_SHIFT = 2;

  // Gain trim geometry
  localparam int SGT_RES_W = 24;
  localparam int SGT_FAC_W = 18;
  localparam int SGT_PROD_W = 42;
  localparam int SGT_GAIN_SHIFT = 16;
  localparam logic signed [SGT_FAC_W-1:0] SGT_UNITY = 18'sh10000;
  localparam logic [SGT_RES_W-1:0] SGT_RES_MAX = 24'h7fffff;
  localparam logic [SGT_RES_W-1:0] SGT_RES_MIN = 24'h800000;

  // Shared pin drive formats
  localparam logic SGT_FMT_PUSH_PULL = 1'b0;
  localparam logic SGT_FMT_OPEN_DRAIN = 1'b1;

  typedef struct packed {
    logic en;
    logic pol;
    logic rsv;
    logic [4:0] num;
  } sgt_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } sgt_reg_req_type;

  typedef struct packed {
    logic [15:0] gain_trim;
    sgt_cfg_type cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [SGT_INT_W-1:0] i1;
    logic [SGT_INT_W-1:0] i2;
    logic [SGT_INT_W-1:0] i3;
    logic [SGT_INT_W-1:0] d1;
    logic [SGT_INT_W-1:0] d2;
    logic [SGT_INT_W-1:0] d3;
    logic [SGT_DEC_W-1:0] dec_cnt;
    logic [7:0] upper_cnt;
    logic [7:0] lower_cnt;
    logic upper_flag;
    logic lower_flag;
    logic [15:0] filt_out;
    logic filt_valid;
    logic [15:0] rdata;
    logic [SGT_RES_W-1:0] result;
    logic result_valid;
    logic fault_level;
    logic pin_out;
    logic pin_oe;
  } sgt_state_type;

  localparam sgt_state_type SGT_STATE_RESET = '{
    gain_trim: SGT_GAIN_RESET,
    cfg: SGT_CFG_RESET,
    upper: SGT_UPPER_RESET,
    lower: SGT_LOWER_RESET,
    default: '0
  };

endpackage

// [hdl/sgt_shunt_trim_ocp.sv]
`timescale 1ns/10ps
module sgt_shunt_trim_ocp
  import sgt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port from the serial front end
  input sgt_reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  // Converter side
  input wire logic converter_enable,
  input wire logic mod_valid,
  input wire logic mod_bit,
  input wire logic result_valid_in,
  input wire logic [SGT_RES_W-1:0] result_in,
  output logic result_valid_out,
  output logic [SGT_RES_W-1:0] result_out,
  // Comparator status
  output logic fast_filter_valid,
  output logic [15:0] fast_filter_value,
  output logic upper_trip_flag,
  output logic lower_trip_flag,
  output logic overcurrent_fault_out,
  // Shared general-purpose pin
  input wire logic shared_pin_source_select,
  input wire logic shared_pin_format,
  input wire logic shared_pin_gpio_level,
  output logic shared_pin_out,
  output logic shared_pin_oe
);

  sgt_state_type st_r;
  sgt_state_type st_nxt;

  logic run;
  logic [SGT_INT_W-1:0] i1;
  logic [SGT_INT_W-1:0] c1;
  logic [SGT_INT_W-1:0] c2;
  logic [SGT_INT_W-1:0] c3;
  logic signed [SGT_CTR_W-1:0] centered;
  logic signed [SGT_CTR_W-1:0] scaled;
  logic [15:0] sample;
  logic upper_exceed;
  logic lower_exceed;
  logic [7:0] limit;
  logic [8:0] upper_step;
  logic [8:0] lower_step;
  logic signed [SGT_FAC_W-1:0] factor;
  logic signed [SGT_PROD_W-1:0] product;
  logic signed [SGT_PROD_W-1:0] trimmed;
  logic fault;
  logic level;

  // Next count and flag of one deglitch counter, packed as {flag, count}
  function automatic logic [8:0] deglitch_step(input logic exceed, input logic [7:0] cnt,
                                               input logic [7:0] lim);
    logic [7:0] next_cnt;
    next_cnt = 8'h00;
    if (exceed) begin
      next_cnt = (cnt >= lim) ? cnt : cnt + 8'h01;
    end
    return {exceed && (next_cnt >= lim), next_cnt};
  endfunction

  // Consecutive fast-filter outputs needed per deglitch code
  function automatic logic [7:0] sgt_deglitch_limit(input logic [4:0] code);
    logic [7:0] lim;
    lim = 8'h01;
    case (code)
      5'h00: lim = 8'h01;
      5'h01: lim = 8'h02;
      5'h02: lim = 8'h03;
      5'h03: lim = 8'h04;
      5'h04: lim = 8'h05;
      5'h05: lim = 8'h06;
      5'h06: lim = 8'h07;
      5'h07: lim = 8'h08;
      5'h08: lim = 8'h09;
      5'h09: lim = 8'h0a;
      5'h0a: lim = 8'h0c;
      5'h0b: lim = 8'h0e;
      5'h0c: lim = 8'h10;
      5'h0d: lim = 8'h12;
      5'h0e: lim = 8'h14;
      5'h0f: lim = 8'h16;
      5'h10: lim = 8'h18;
      5'h11: lim = 8'h1c;
      5'h12: lim = 8'h20;
      5'h13: lim = 8'h24;
      5'h14: lim = 8'h28;
      5'h15: lim = 8'h30;
      5'h16: lim = 8'h38;
      5'h17: lim = 8'h40;
      5'h18: lim = 8'h48;
      5'h19: lim = 8'h50;
      5'h1a: lim = 8'h58;
      5'h1b: lim = 8'h60;
      5'h1c: lim = 8'h68;
      5'h1d: lim = 8'h70;
      5'h1e: lim = 8'h78;
      5'h1f: lim = 8'h80;
      default: lim = 8'h01;
    endcase
    return lim;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_nxt = st_r;
    st_nxt.filt_valid = 1'b0;
    st_nxt.result_valid = 1'b0;
    i1 = '0;
    c1 = '0;
    c2 = '0;
    c3 = '0;
    centered = '0;
    scaled = '0;
    sample = 16'h0000;
    upper_exceed = 1'b0;
    lower_exceed = 1'b0;
    limit = sgt_deglitch_limit(st_r.cfg.num);
    upper_step = 9'h000;
    lower_step = 9'h000;
    factor = '0;
    product = '0;
    trimmed = '0;
    fault = 1'b0;
    level = 1'b0;

    // Register writes; bit 13 is stored as written
    if (reg_req.wr) begin
      case (reg_req.addr)
        SGT_ADDR_GAIN: begin
          st_nxt.gain_trim = reg_req.wdata;
        end
        SGT_ADDR_CFG: begin
          st_nxt.cfg = sgt_cfg_type'(reg_req.wdata[SGT_CFG_MSB:SGT_CFG_LSB]);
        end
        SGT_ADDR_UPPER: begin
          st_nxt.upper = reg_req.wdata;
        end
        SGT_ADDR_LOWER: begin
          st_nxt.lower = reg_req.wdata;
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (reg_req.rd) begin
      case (reg_req.addr)
        SGT_ADDR_GAIN: begin
          st_nxt.rdata = st_r.gain_trim;
        end
        SGT_ADDR_CFG: begin
          st_nxt.rdata = {st_r.cfg, SGT_CFG_LOW_READ};
        end
        SGT_ADDR_UPPER: begin
          st_nxt.rdata = st_r.upper;
        end
        SGT_ADDR_LOWER: begin
          st_nxt.rdata = st_r.lower;
        end
        default: begin
          st_nxt.rdata = SGT_RDATA_NONE;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain trim of the conversion result

    if (result_valid_in) begin
      factor = SGT_UNITY + SGT_FAC_W'($signed(st_r.gain_trim));
      product = SGT_PROD_W'($signed(result_in)) * SGT_PROD_W'(factor);
      trimmed = product >>> SGT_GAIN_SHIFT;
      st_nxt.result_valid = 1'b1;
      // Clip to the 24-bit limits rather than wrap
      if (trimmed[SGT_PROD_W-1:SGT_RES_W-1] != {(SGT_PROD_W - SGT_RES_W + 1){1'b0}} &&
          trimmed[SGT_PROD_W-1:SGT_RES_W-1] != {(SGT_PROD_W - SGT_RES_W + 1){1'b1}}) begin
        st_nxt.result = trimmed[SGT_PROD_W-1] ? SGT_RES_MIN : SGT_RES_MAX;
      end else begin
        st_nxt.result = trimmed[SGT_RES_W-1:0];
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fast filter and threshold comparator

    // Runs on the modulator stream only while cfg.en and converter_enable are both set; dropping either clears its integrators, counters and flags
    run = st_r.cfg.en && converter_enable;
    if (!run) begin
      st_nxt.i1 = '0;
      st_nxt.i2 = '0;
      st_nxt.i3 = '0;
      st_nxt.d1 = '0;
      st_nxt.d2 = '0;
      st_nxt.d3 = '0;
      st_nxt.dec_cnt = '0;
      st_nxt.upper_cnt = 8'h00;
      st_nxt.lower_cnt = 8'h00;
      st_nxt.upper_flag = 1'b0;
      st_nxt.lower_flag = 1'b0;
    end else if (mod_valid) begin
      i1 = st_r.i1 + SGT_INT_W'(mod_bit);
      st_nxt.i1 = i1;
      st_nxt.i2 = st_r.i2 + i1;
      st_nxt.i3 = st_r.i3 + st_nxt.i2;
      st_nxt.dec_cnt = st_r.dec_cnt + SGT_DEC_W'(1);
      if (st_r.dec_cnt == SGT_DEC_LAST) begin
        c1 = st_nxt.i3 - st_r.d1;
        c2 = c1 - st_r.d2;
        c3 = c2 - st_r.d3;
        st_nxt.d1 = st_nxt.i3;
        st_nxt.d2 = c1;
        st_nxt.d3 = c2;
        centered = $signed({1'b0, c3}) - SGT_MID;
        scaled = centered >>> SGT_SHIFT;
        sample = (scaled > SGT_SCALED_MAX) ? SGT_POS_FS : scaled[15:0];
        st_nxt.filt_out = sample;
        st_nxt.filt_valid = 1'b1;
        upper_exceed = (st_r.upper != SGT_POS_FS) &&
                       ($signed(sample) > $signed(st_r.upper));
        lower_exceed = (st_r.lower != SGT_NEG_FS) &&
                       ($signed(sample) < $signed(st_r.lower));
        upper_step = deglitch_step(upper_exceed, st_r.upper_cnt, limit);
        lower_step = deglitch_step(lower_exceed, st_r.lower_cnt, limit);
        st_nxt.upper_cnt = upper_step[7:0];
        st_nxt.upper_flag = upper_step[8];
        st_nxt.lower_cnt = lower_step[7:0];
        st_nxt.lower_flag = lower_step[8];
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault level and shared pin drive

    // With shared_pin_source_select set, pin drives the fault level (push-pull) or pulls low while it is low (open drain), one cycle behind the flags
    fault = st_r.upper_flag || st_r.lower_flag;
    level = st_r.cfg.pol ? fault : !fault;
    st_nxt.fault_level = level;
    if (shared_pin_source_select) begin
      if (shared_pin_format == SGT_FMT_OPEN_DRAIN) begin
        st_nxt.pin_out = 1'b0;
        st_nxt.pin_oe = !level;
      end else begin
        st_nxt.pin_out = level;
        st_nxt.pin_oe = 1'b1;
      end
    end else begin
      if (shared_pin_format == SGT_FMT_OPEN_DRAIN) begin
        st_nxt.pin_out = 1'b0;
        st_nxt.pin_oe = !shared_pin_gpio_level;
      end else begin
        st_nxt.pin_out = shared_pin_gpio_level;
        st_nxt.pin_oe = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= SGT_STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign result_valid_out = st_r.result_valid;
  assign result_out = st_r.result;
  assign fast_filter_valid = st_r.filt_valid;
  assign fast_filter_value = st_r.filt_out;
  assign upper_trip_flag = st_r.upper_flag;
  assign lower_trip_flag = st_r.lower_flag;
  assign overcurrent_fault_out = st_r.fault_level;
  assign shared_pin_out = st_r.pin_out;
  assign shared_pin_oe = st_r.pin_oe;

endmodule

// [tb/sgt_shunt_trim_ocp_assertions.sv]
`timescale 1ns/10ps
module sgt_chk
  import sgt_pkg::*;
(
  // Clock, reset and registers
  input wire logic clk,
  input wire logic reset_n,
  input sgt_reg_req_type reg_req,
  input wire logic [15:0] reg_rdata,
  // Converter and filter
  input wire logic converter_enable,
  input wire logic mod_valid,
  input wire logic result_valid_in,
  input wire logic result_valid_out,
  input wire logic fast_filter_valid,
  input wire logic [15:0] fast_filter_value,
  // Fault and shared pin
  input wire logic upper_trip_flag,
  input wire logic lower_trip_flag,
  input wire logic overcurrent_fault_out,
  input wire logic shared_pin_source_select,
  input wire logic shared_pin_format,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow of the upper limit and polarity as the host writes them
  logic [15:0] up_r;
  logic pol_r;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      up_r <= SGT_UPPER_RESET;
      pol_r <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == SGT_ADDR_UPPER) begin
      up_r <= reg_req.wdata;
    end else if (reg_req.wr && reg_req.addr == SGT_ADDR_CFG) begin
      pol_r <= reg_req.wdata[14];
    end
  end
  property p_trim; result_valid_in |=> result_valid_out; endproperty
  a_trim: assert property (p_trim) else $error("trim valid missing");
  property p_src; fast_filter_valid |-> $past(converter_enable) && $past(mod_valid); endproperty
  a_src: assert property (p_src) else $error("filter sample without input");
  property p_off; !converter_enable |=> !upper_trip_flag && !lower_trip_flag; endproperty
  a_off: assert property (p_off) else $error("flag while disabled");
  // Fault level is built from the polarity of the cycle before
  property p_act; reset_n && (upper_trip_flag || lower_trip_flag)
    |=> overcurrent_fault_out == $past(pol_r); endproperty
  a_act: assert property (p_act) else $error("fault level wrong");
  property p_idle; reset_n && !upper_trip_flag && !lower_trip_flag
    |=> overcurrent_fault_out != $past(pol_r); endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");
  property p_up; fast_filter_valid && upper_trip_flag
    |-> $signed(fast_filter_value) > $signed($past(up_r)) && $past(up_r) != SGT_POS_FS;
  endproperty
  a_up: assert property (p_up) else $error("upper flag unjustified");
  property p_clr; fast_filter_valid && $signed(fast_filter_value) <= $signed($past(up_r))
    |-> !upper_trip_flag; endproperty
  a_clr: assert property (p_clr) else $error("upper flag kept");
  property p_rsv; reg_req.rd && reg_req.addr == SGT_ADDR_CFG |=> reg_rdata[7:0] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read");
  property p_pin; $past(reset_n) && $past(shared_pin_source_select) && !$past(shared_pin_format)
    |-> shared_pin_oe && shared_pin_out == overcurrent_fault_out; endproperty
  a_pin: assert property (p_pin) else $error("pin not following fault");
endmodule
bind sgt_shunt_trim_ocp sgt_chk u_chk (.*);

// [tb/sgt_host_model.sv]
`timescale 1ns/10ps
module sgt_host
  import sgt_pkg::*;
(
  // Register port
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  output sgt_reg_req_type reg_req
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    if (a == SGT_ADDR_CFG) d[13] = 1'b0;
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// [tb/sgt_shunt_trim_ocp_tb.sv]
`timescale 1ns/10ps
module sgt_shunt_trim_ocp_tb;
  import sgt_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  sgt_reg_req_type reg_req;
  logic [15:0] reg_rdata, fast_filter_value, rd_v;
  logic converter_enable = 1'b0;
  logic mod_valid = 1'b0;
  logic mod_bit = 1'b0;
  logic result_valid_in = 1'b0;
  logic [SGT_RES_W-1:0] result_in = 24'h000000;
  logic [SGT_RES_W-1:0] result_out;
  logic result_valid_out, fast_filter_valid, upper_trip_flag, lower_trip_flag;
  logic overcurrent_fault_out, shared_pin_out, shared_pin_oe;
  logic shared_pin_source_select = 1'b1;
  logic shared_pin_format = 1'b0;
  logic shared_pin_gpio_level = 1'b0;
  int fails = 0;
  int checked = 0;
  always #50 clk = ~clk;
  sgt_shunt_trim_ocp dut (.*);
  sgt_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [23:0] trim(input logic [23:0] x, input logic [15:0] g);
    longint p;
    p = (longint'($signed(x)) * (65536 + longint'($signed(g)))) >>> 16;
    if (p > 8388607) p = 8388607;
    if (p < -8388608) p = -8388608;
    return p[23:0];
  endfunction
  task automatic restart(input logic b);
    @(posedge clk);
    converter_enable <= 1'b0;
    mod_bit <= b;
    @(posedge clk);
    converter_enable <= 1'b1;
  endtask
  task automatic next_out;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (fast_filter_valid !== 1'b1 && i < 80);
    cmp("filter valid", 1'b1, fast_filter_valid);
  endtask
  task automatic t_regs;
    logic [15:0] e [5] = '{16'h0000, 16'h0000, 16'h7fff, 16'h8000, 16'h0000};
    host.wr(8'h8a, 16'hffff);
    for (int i = 0; i < 5; i++) begin
      host.rd(8'h86 + 8'(i), rd_v);
      cmp("reset value", e[i], rd_v);
    end
    host.wr(SGT_ADDR_CFG, 16'h7fff);
    host.rd(SGT_ADDR_CFG, rd_v);
    cmp("config", 16'h5f00, rd_v);
  endtask
  task automatic t_trim;
    logic [15:0] g [4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0001};
    logic [23:0] x [4] = '{24'h7fffff, 24'h100000, 24'hffffff, 24'h800000};
    for (int i = 0; i < 4; i++) begin
      host.wr(SGT_ADDR_GAIN, g[i]);
      @(posedge clk);
      result_valid_in <= 1'b1;
      result_in <= x[i];
      @(posedge clk);
      result_valid_in <= 1'b0;
      #1 cmp("trim", trim(x[i], g[i]), result_out);
      cmp("trim valid", 1'b1, result_valid_out);
    end
  endtask
  task automatic t_deglitch(input logic [4:0] code, input int n);
    host.wr(SGT_ADDR_CFG, {3'b100, code, 8'h00});
    restart(1'b1);
    repeat (n) next_out;
    cmp("early flag", 1'b0, upper_trip_flag);
    next_out;
    cmp("flag", 1'b1, upper_trip_flag);
  endtask
  task automatic t_filter;
    restart(1'b1);
    repeat (70) @(posedge clk);
    #1 cmp("filter idle", 16'h0000, fast_filter_value);
    host.wr(SGT_ADDR_CFG, 16'h8000);
    restart(1'b1);
    repeat (3) next_out;
    cmp("filter value", 16'h7fff, fast_filter_value);
    cmp("upper off", 1'b0, upper_trip_flag);
    host.wr(SGT_ADDR_UPPER, 16'h0000);
    t_deglitch(5'h00, 1);
    t_deglitch(5'h02, 3);
    t_deglitch(5'h0a, 12);
    @(posedge clk);
    mod_bit <= 1'b0;
    repeat (4) next_out;
    cmp("flag clear", 1'b0, upper_trip_flag);
    cmp("low value", 16'h8000, fast_filter_value);
    cmp("lower off", 1'b0, lower_trip_flag);
  endtask
  task automatic t_lower;
    host.wr(SGT_ADDR_CFG, 16'h8000);
    host.wr(SGT_ADDR_LOWER, 16'h0000);
    repeat (2) next_out;
    cmp("lower flag", 1'b1, lower_trip_flag);
    @(posedge clk);
    #1 cmp("fault low", 1'b0, overcurrent_fault_out);
    host.wr(SGT_ADDR_CFG, 16'hc000);
    @(posedge clk);
    #1 cmp("fault high", 1'b1, overcurrent_fault_out);
    @(posedge clk);
    shared_pin_format <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp("drain enable", 1'b0, shared_pin_oe);
    @(posedge clk);
    shared_pin_source_select <= 1'b0;
    shared_pin_format <= 1'b0;
    shared_pin_gpio_level <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp("gpio level", 1'b1, shared_pin_out);
  endtask
  initial begin
    #500000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    mod_valid <= 1'b1;
    t_regs;
    t_trim;
    t_filter;
    t_lower;
    end_sim;
  end
endmodule
